// ==== core/hiocp_top.sv ====
// Host I/O control port: command, status and memory window registers.
// Assumes host strobes, address and pins arrive asynchronously; data is 16 bits.
// ********************************************
// ********************************************
`timescale 1ns/1ps
`include "hiocp_regs.svh"
module hiocp_top
(
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic io_wr,
	input wire logic io_rd,
	input wire logic [2:0] io_addr,
	input wire logic [15:0] io_wdata,
	input wire logic mem_cyc,
	input wire logic [4:0] la_hi,
	input wire logic dsp_hold_ack,
	input wire logic dsp_host_irq,
	input wire logic dma_tc,
	input wire logic fifo_irq,
	output logic [15:0] io_rdata,
	output logic window_hit,
	output hiocp_pkg::hiocp_cmd_s cmd_out,
	output logic dsp_irq,
	output logic dsp_hold_req,
	output logic dsp_reset_n,
	output logic [6:0] host_irq_lines,
	output logic dma_req
);
	import hiocp_pkg::*;
	// ********************************************
	// Reset release and input synchronisers
	// ********************************************
	logic rs1_q, rst_n;
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			rs1_q <= 1'b0;
			rst_n <= 1'b0;
		end
		else
		begin
			rs1_q <= 1'b1;
			rst_n <= rs1_q;
		end
	end
	logic [6:0] sin, sq;
	assign sin = {io_wr, io_rd, mem_cyc, dsp_hold_ack, dsp_host_irq, dma_tc, fifo_irq};
	genvar g;
	generate
		for (g = 0; g < 7; g = g + 1)
		begin : g_sync
			hiocp_sync u_sync
			(
				.clk(core_clk),
				.rst_n(rst_n),
				.d(sin[g]),
				.q(sq[g])
			);
		end
	endgenerate
	logic wr_s, rd_s, mem_s, ack_s, dirq_s, tc_s, fifo_s;
	assign {wr_s, rd_s, mem_s, ack_s, dirq_s, tc_s, fifo_s} = sq;
	// Address and data lines are sampled only on the strobe edge, once they have settled; LA lines are compared every cycle.
	// ********************************************
	// Registers
	// ********************************************
	hiocp_cmd_s cmd_q, cmd_d;
	hiocp_win_s win_q, win_d;
	logic wr_dly_q, rd_dly_q, mem_dly_q, fifo_dly_q, tc_seen_q, tc_seen_d;
	logic [15:0] rdata_q, rdata_d;
	logic hit_q, hit_d, irq_q, irq_d, dma_q, dma_d, hreq_q, hreq_d;
	logic [6:0] lines_q, lines_d;
	hiocp_dyn_e dyn_q, dyn_d;
	logic wr_p, rd_p, mem_p, fifo_p, match;
	always_comb
	begin
		wr_p = wr_s & ~wr_dly_q;
		rd_p = rd_s & ~rd_dly_q;
		mem_p = mem_s & ~mem_dly_q;
		fifo_p = fifo_s & ~fifo_dly_q;
		match = win_q.en && (la_hi == win_q.base);
		cmd_d = cmd_q;
		win_d = win_q;
		rdata_d = rdata_q;
		tc_seen_d = tc_seen_q | tc_s;
		if (wr_p && io_addr == `HIOCP_OFS_CMD)
		begin
			cmd_d = hiocp_cmd_s'(io_wdata[7:0]);
		end
		if (wr_p && io_addr == `HIOCP_OFS_WIN)
		begin
			win_d = hiocp_win_s'(io_wdata[`HIOCP_WIN_BASE_MSB:`HIOCP_WIN_EN]);
		end
		if (rd_p)
		begin
			rdata_d = 16'h0000;
			if (io_addr == `HIOCP_OFS_CMD)
			begin
				rdata_d[`HIOCP_STS_TC] = tc_seen_q;
				rdata_d[`HIOCP_STS_HACK] = ack_s;
				tc_seen_d = tc_s; // Reading clears the sticky count; a new one wins.
			end
		end
		// Dynamic hold: a window hit with no held mode requests the bus for that access.
		dyn_d = dyn_q;
		case (dyn_q)
			HIOCP_IDLE:
			begin
				if (mem_p && match && !cmd_q.hold)
				begin
					dyn_d = HIOCP_REQ;
				end
			end
			HIOCP_REQ:
			begin
				if (ack_s)
				begin
					dyn_d = HIOCP_ACC;
				end
			end
			HIOCP_ACC:
			begin
				if (!mem_s)
				begin
					dyn_d = HIOCP_IDLE;
				end
			end
			default:
			begin
				dyn_d = HIOCP_IDLE;
			end
		endcase
		hreq_d = cmd_q.hold | (dyn_d != HIOCP_IDLE);
		hit_d = match & mem_s & (ack_s | cmd_q.hold);
		irq_d = cmd_q.dsp_irq;
		// FIFO pulses start DMA only while enabled; DSP keeps running meanwhile.
		dma_d = (fifo_p | (dma_q & ~tc_s)) & (cmd_q.dma != 2'b00);
		lines_d = 7'h00;
		if ((dirq_s | tc_seen_q) && cmd_q.irq_sel != 3'h0 && cmd_q.irq_sel != 3'h7)
		begin
			lines_d[cmd_q.irq_sel] = 1'b1;
		end
		else if ((dirq_s | tc_seen_q) && cmd_q.irq_sel == 3'h7)
		begin
			lines_d[0] = 1'b1;
		end
	end
	// Level map: sel 7 drives level 7 on line 0; sel 1..5 drive 9..12,15 on lines 1..5; sel 6 line 6 spare.
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cmd_q <= hiocp_cmd_s'(`HIOCP_CMD_RST);
			win_q <= hiocp_win_s'(6'h00);
			wr_dly_q <= 1'b0;
			rd_dly_q <= 1'b0;
			mem_dly_q <= 1'b0;
			fifo_dly_q <= 1'b0;
			tc_seen_q <= 1'b0;
			rdata_q <= 16'h0000;
			hit_q <= 1'b0;
			irq_q <= 1'b0;
			dma_q <= 1'b0;
			hreq_q <= 1'b0;
			lines_q <= 7'h00;
			dyn_q <= HIOCP_IDLE;
		end
		else
		begin
			cmd_q <= cmd_d;
			win_q <= win_d;
			wr_dly_q <= wr_s;
			rd_dly_q <= rd_s;
			mem_dly_q <= mem_s;
			fifo_dly_q <= fifo_s;
			tc_seen_q <= tc_seen_d;
			rdata_q <= rdata_d;
			hit_q <= hit_d;
			irq_q <= irq_d;
			dma_q <= dma_d;
			hreq_q <= hreq_d;
			lines_q <= lines_d;
			dyn_q <= dyn_d;
		end
	end
	// ********************************************
	// Outputs
	// ********************************************
	assign io_rdata = rdata_q;
	assign window_hit = hit_q;
	assign cmd_out = cmd_q;
	assign dsp_irq = irq_q;
	assign dsp_hold_req = hreq_q;
	assign dsp_reset_n = cmd_q.run;
	assign host_irq_lines = lines_q;
	assign dma_req = dma_q;
endmodule

// ==== core/hiocp_regs.svh ====
// Register offsets, field positions and reset values of the host I/O control port.
// Assumes byte-addressed host I/O cycles relative to the board's I/O base.
`ifndef HIOCP_REGS_SVH
`define HIOCP_REGS_SVH
// ********************************************
// Offsets
// ********************************************
`define HIOCP_OFS_CMD 3'h0
`define HIOCP_OFS_WIN 3'h2
// ********************************************
// Command fields
// ********************************************
`define HIOCP_CMD_IRQ_LSB 0
`define HIOCP_CMD_IRQ_MSB 2
`define HIOCP_CMD_DMA_LSB 3
`define HIOCP_CMD_DMA_MSB 4
`define HIOCP_CMD_DSPIRQ 5
`define HIOCP_CMD_HOLD 6
`define HIOCP_CMD_RUN 7
// ********************************************
// Status and window fields, reset values
// ********************************************
`define HIOCP_STS_TC 6
`define HIOCP_STS_HACK 7
`define HIOCP_WIN_EN 2
`define HIOCP_WIN_BASE_LSB 3
`define HIOCP_WIN_BASE_MSB 7
`define HIOCP_CMD_RST 8'h00
`define HIOCP_WIN_RST 8'h00
`endif

// ==== core/hiocp_pkg.sv ====
// Types shared by the host I/O control port.
// Assumes the offsets header is included by the design files.
package hiocp_pkg;
	typedef struct packed
	{
		logic run;
		logic hold;
		logic dsp_irq;
		logic [1:0] dma;
		logic [2:0] irq_sel;
	} hiocp_cmd_s;
	typedef struct packed
	{
		logic [4:0] base;
		logic en;
	} hiocp_win_s;
	typedef enum logic [1:0]
	{
		HIOCP_IDLE = 2'b00,
		HIOCP_REQ = 2'b01,
		HIOCP_ACC = 2'b10
	} hiocp_dyn_e;
endpackage

// ==== core/hiocp_sync.sv ====
// Two-flop synchroniser for one level.
// Assumes the input is asynchronous to clk.
`timescale 1ns/1ps
module hiocp_sync
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic d,
	output logic q
);
	logic s1_q;
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s1_q <= 1'b0;
			q <= 1'b0;
		end
		else
		begin
			s1_q <= d;
			q <= s1_q;
		end
	end
endmodule

// ==== verif/hiocp_asserts.sv ====
// Port checker for hiocp_top.
// Assumes the host holds io_addr and io_wdata while its strobe is high.
`timescale 1ns/1ps
module hiocp_asserts
(
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic io_wr,
	input wire logic io_rd,
	input wire logic [2:0] io_addr,
	input wire logic [15:0] io_wdata,
	input wire logic dsp_hold_ack,
	input wire logic [15:0] io_rdata,
	input wire hiocp_pkg::hiocp_cmd_s cmd_out,
	input wire logic dsp_irq,
	input wire logic dsp_hold_req,
	input wire logic dsp_reset_n,
	input wire logic dma_req
);
	import hiocp_pkg::*;
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (!nrst);
	property p_cmd; $rose(io_wr) && io_addr == 3'h0 |-> ##[3:5] cmd_out == io_wdata[7:0]; endproperty
	a_cmd: assert property (p_cmd) else $error("cmd");
	property p_dma; (cmd_out.dma == 2'h0) [*4] |-> !dma_req; endproperty
	a_dma: assert property (p_dma) else $error("dma");
	property p_irq; $rose(cmd_out.dsp_irq) |=> dsp_irq; endproperty
	a_irq: assert property (p_irq) else $error("irq");
	property p_hold; cmd_out.hold |=> dsp_hold_req; endproperty
	a_hold: assert property (p_hold) else $error("hold");
	property p_run; $rose(io_wr) && io_addr == 3'h0 |-> ##4 dsp_reset_n == io_wdata[7]; endproperty
	a_run: assert property (p_run) else $error("run");
	property p_ack; $rose(io_rd) && io_addr == 3'h0 |-> ##4 io_rdata[7] == $past(dsp_hold_ack, 4); endproperty
	a_ack: assert property (p_ack) else $error("ack");
	property p_sts; io_rdata[15:8] == 8'h00 && io_rdata[5:0] == 6'h00; endproperty
	a_sts: assert property (p_sts) else $error("sts");
	property p_win; $rose(io_rd) && io_addr == 3'h2 |-> ##[4:5] io_rdata == 16'h0000; endproperty
	a_win: assert property (p_win) else $error("win");
endmodule
bind hiocp_top hiocp_asserts hiocp_asserts_inst
(
	.core_clk(core_clk),
	.nrst(nrst),
	.io_wr(io_wr),
	.io_rd(io_rd),
	.io_addr(io_addr),
	.io_wdata(io_wdata),
	.dsp_hold_ack(dsp_hold_ack),
	.io_rdata(io_rdata),
	.cmd_out(cmd_out),
	.dsp_irq(dsp_irq),
	.dsp_hold_req(dsp_hold_req),
	.dsp_reset_n(dsp_reset_n),
	.dma_req(dma_req)
);

// ==== verif/hiocp_host_bfm.sv ====
// Host model: I/O write and read cycles.
// Assumes tasks start just after a rising edge.
`timescale 1ns/1ps
module hiocp_host_bfm
(
	input wire logic core_clk,
	input wire logic [15:0] io_rdata,
	output logic io_wr,
	output logic io_rd,
	output logic [2:0] io_addr,
	output logic [15:0] io_wdata
);
	initial {io_wr, io_rd, io_addr, io_wdata} = '0;
	task automatic cyc(input logic rd, input logic [2:0] a, input logic [15:0] d, output logic [15:0] q);
		io_addr <= a;
		io_wdata <= d;
		@(posedge core_clk);
		io_wr <= !rd;
		io_rd <= rd;
		repeat (6) @(posedge core_clk);
		q = io_rdata;
		io_wr <= 1'b0;
		io_rd <= 1'b0;
		repeat (4) @(posedge core_clk);
		// Released lines float, so a stale value must not pass.
		io_addr <= ~a;
		io_wdata <= ~d;
		@(posedge core_clk);
	endtask
endmodule

// ==== verif/tb_top.sv ====
// Bench for hiocp_top.
// Assumes the host model drives the I/O strobes.
`timescale 1ns/1ps
`define CHK(g, e) \
begin \
	n_checks++; \
	if ((g) !== (e)) \
	begin \
		err_count++; \
		$display("[ERR] %0t got %h exp %h", $time, g, e); \
	end \
end
module tb_top;
	import hiocp_pkg::*;
	logic core_clk = '0, nrst = '0, dsp_hold_ack = '0, dsp_host_irq = '0, dma_tc = '0, fifo_irq = '0, mem_cyc = '0;
	logic io_wr, io_rd, window_hit, dsp_irq, dsp_hold_req, dsp_reset_n, dma_req;
	logic [2:0] io_addr;
	logic [4:0] la_hi = '0;
	logic [15:0] io_wdata, io_rdata, res, q;
	logic [6:0] host_irq_lines;
	logic [3:0] ack_q = '0;
	logic [31:0] lfsr = 32'h8a22cdbb;
	hiocp_cmd_s cmd_out;
	logic [15:0] exp_q[$];
	logic [15:0] exp_v;
	int err_count = 0, n_checks = 0, cyc_n = 0;
	event seen;
	hiocp_top hiocp_top_inst
	(
		.core_clk(core_clk),
		.nrst(nrst),
		.io_wr(io_wr),
		.io_rd(io_rd),
		.io_addr(io_addr),
		.io_wdata(io_wdata),
		.mem_cyc(mem_cyc),
		.la_hi(la_hi),
		.dsp_hold_ack(dsp_hold_ack),
		.dsp_host_irq(dsp_host_irq),
		.dma_tc(dma_tc),
		.fifo_irq(fifo_irq),
		.io_rdata(io_rdata),
		.window_hit(window_hit),
		.cmd_out(cmd_out),
		.dsp_irq(dsp_irq),
		.dsp_hold_req(dsp_hold_req),
		.dsp_reset_n(dsp_reset_n),
		.host_irq_lines(host_irq_lines),
		.dma_req(dma_req)
	);
	hiocp_host_bfm hiocp_host_bfm_inst
	(
		.core_clk(core_clk),
		.io_rdata(io_rdata),
		.io_wr(io_wr),
		.io_rd(io_rd),
		.io_addr(io_addr),
		.io_wdata(io_wdata)
	);
	always #4 core_clk = ~core_clk;
	// The DSP grants a hold late, so the host must poll.
	always @(posedge core_clk)
	begin
		ack_q <= {ack_q[2:0], dsp_hold_req};
		dsp_hold_ack <= ack_q[3];
		cyc_n <= cyc_n + 1;
		if (cyc_n == 3000)
		begin
			err_count++;
			conclude();
		end
	end
	// The note is taken off once, so a mismatch report cannot eat the next note.
	always @(seen)
	begin
		exp_v = exp_q.pop_front();
		`CHK(res, exp_v)
	end
	task automatic conclude;
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	function automatic logic [31:0] step(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic look(input logic [15:0] v, input logic [15:0] e);
		exp_q.push_back(e);
		res = v;
		-> seen;
		@(posedge core_clk);
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		lfsr = step(lfsr);
		hiocp_host_bfm_inst.cyc(1'b0, a, {lfsr[15:8], d}, q);
	endtask
	task automatic rd(input logic [2:0] a, input logic [15:0] e);
		hiocp_host_bfm_inst.cyc(1'b1, a, 16'h0000, q);
		look(q, e);
	endtask
	task automatic mem(input logic [4:0] la, input logic e);
		la_hi <= la;
		@(posedge core_clk);
		mem_cyc <= 1'b1;
		repeat (20) @(posedge core_clk);
		look(16'(window_hit), 16'(e));
		mem_cyc <= 1'b0;
	endtask
	initial
	begin
		repeat (6) @(posedge core_clk);
		nrst <= 1'b1;
		dma_tc <= 1'b1;
		repeat (8) @(posedge core_clk);
		dma_tc <= 1'b0;
		rd(3'h0, 16'h0040);
		rd(3'h0, 16'h0000);
		dsp_host_irq <= 1'b1;
		for (int s = 1; s < 8; s++)
		begin
			wr(3'h0, 8'h80 | 8'(s));
			look(16'(cmd_out), 16'h0080 | 16'(s));
			look(16'(host_irq_lines), 16'(7'h01 << ((s == 7) ? 0 : s)));
		end
		dsp_host_irq <= 1'b0;
		look(16'(dsp_reset_n), 16'h0001);
		wr(3'h0, 8'hc0);
		look(16'(dsp_hold_req), 16'h0001);
		rd(3'h0, 16'h0080);
		wr(3'h2, 8'h57);
		mem(5'h0a, 1'b1);
		mem(5'h0b, 1'b0);
		rd(3'h2, 16'h0000);
		wr(3'h2, 8'h53);
		mem(5'h0a, 1'b0);
		wr(3'h2, 8'h54);
		wr(3'h0, 8'h80);
		mem(5'h0a, 1'b1);
		wr(3'h0, 8'ha8);
		look(16'(dsp_irq), 16'h0001);
		fifo_irq <= 1'b1;
		repeat (8) @(posedge core_clk);
		look(16'(dma_req), 16'h0001);
		dma_tc <= 1'b1;
		repeat (8) @(posedge core_clk);
		look(16'(dma_req), 16'h0000);
		nrst <= 1'b0;
		repeat (3) @(posedge core_clk);
		look(16'(cmd_out), 16'h0000);
		conclude();
	end
endmodule
